/* File: dv/dbu_core_model.sv */
// Core pipeline model: presents memory accesses and retire-side events.
// Assumes a free-running ref_clk; drives only just after its falling edge.
`timescale 1ns/1ps
module dbu_core_model (
  input  wire logic                 ref_clk,
  output      dbu_pkg::dbu_access_t access,
  output      dbu_pkg::dbu_event_t  evt
);
  // Quiet bus at time zero
  initial begin
    access = '0;
    evt    = '0;
  end
  // One cycle of access and events, shown ahead of completion
  task automatic pulse(input logic [2:0] k, input logic [31:0] a, input logic [4:0] e);
    @(negedge ref_clk);
    access <= {k, a};
    evt    <= e;
    @(negedge ref_clk);
    access <= {3'h0, ~a}; // Stale address inverted so it is never reused
    evt    <= '0;
  endtask
endmodule

/* File: dv/tb_debug_breakpoint_unit.sv */
// Self-checking bench: register moves, breakpoint matching, step,
// task-switch, guard traps. Assumes the core model drives on falling edges.
`timescale 1ns/1ps
module tb_debug_breakpoint_unit;
  logic                 ref_clk;
  logic                 rst;
  dbu_pkg::dbu_move_t   move;
  dbu_pkg::dbu_access_t access;
  dbu_pkg::dbu_event_t  evt;
  dbu_pkg::dbu_reply_t  reply;
  logic                 debugExc;
  logic                 privFault;
  dbu_pkg::dbu_reply_t  lastRep;
  logic                 lastEx;
  logic                 lastPf;
  int                   failures;
  int                   checksDone;
  logic [31:0]          bpAddr [4] = '{32'h1000, 32'h2000, 32'h3100, 32'h4002};
  localparam logic [31:0] STS0 = dbu_pkg::STS_FIXED_ONES;
  localparam logic [31:0] CTL = 32'h7f100429;

  dbu_debug_breakpoint_unit dut (.ref_clk(ref_clk), .rst(rst), .access(access), .move(move),
    .evt(evt), .reply(reply), .debugExc(debugExc), .privFault(privFault));
  dbu_core_model core (.ref_clk(ref_clk), .access(access), .evt(evt));

  // 250 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One move request; the answer is sampled in the following cycle
  task automatic mv(input logic w, input logic [2:0] s, input logic [1:0] p, input logic [31:0] d);
    @(negedge ref_clk);
    move <= {1'b1, w, s, p, d};
    @(negedge ref_clk);
    lastRep = reply;
    lastEx  = debugExc;
    lastPf  = privFault;
    move    <= {2'h0, 3'h5, 2'h3, ~d};
  endtask

  task automatic rd(input logic [2:0] s, input logic [31:0] exp, input string what);
    mv(1'b0, s, dbu_pkg::PRIV_KERNEL, 32'h0);
    chk({30'h0, lastRep.done, lastRep.fault}, 32'h2, what);
    chk(lastRep.rdata, exp, what);
  endtask

  // Access/event cycle, exception check, status check, then software clear
  task automatic hit(input logic [2:0] k, input logic [31:0] a, input logic [4:0] e,
                     input logic x, input logic [31:0] sts);
    core.pulse(k, a, e);
    chk({31'h0, debugExc}, {31'h0, x}, "exception");
    rd(dbu_pkg::SEL_STATUS, sts, "status");
    mv(1'b1, dbu_pkg::SEL_STATUS, dbu_pkg::PRIV_KERNEL, STS0); // Fixed bits kept
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end

  initial begin
    failures   = 0;
    checksDone = 0;
    rst        = 1'b1;
    move       = '0;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    // Reset values and address storage
    for (int i = 0; i < 4; i++) rd(3'(i), dbu_pkg::ADDR_RESET, "addr reset");
    rd(dbu_pkg::SEL_STATUS, dbu_pkg::STS_RESET, "status reset");
    rd(dbu_pkg::SEL_CONTROL, dbu_pkg::CTL_RESET, "control reset");
    for (int i = 0; i < 4; i++) mv(1'b1, 3'(i), dbu_pkg::PRIV_KERNEL, bpAddr[i]);
    for (int i = 0; i < 4; i++) rd(3'(i), bpAddr[i], "addr readback");
    mv(1'b1, dbu_pkg::SEL_CONTROL, dbu_pkg::PRIV_KERNEL, CTL);
    rd(dbu_pkg::SEL_CONTROL, (CTL & dbu_pkg::CTL_WRITE_MASK) | dbu_pkg::CTL_FIXED_ONES, "control");
    $display("test registers done");
    // Refused moves: low privilege, unmapped select
    mv(1'b1, dbu_pkg::SEL_ADDR0, 2'h3, 32'h55);
    chk({30'h0, lastPf, lastRep.done}, 32'h2, "priv fault");
    rd(dbu_pkg::SEL_ADDR0, bpAddr[0], "addr kept");
    mv(1'b0, 3'h4, dbu_pkg::PRIV_KERNEL, 32'h0);
    chk({30'h0, lastRep.done, lastRep.fault}, 32'h3, "unmapped");
    $display("test refusals done");
    // Breakpoint types, lengths and hit flags
    hit(3'h6, 32'h1000, 5'h00, 1'b1, STS0 | 32'h1);
    hit(3'h6, 32'h1001, 5'h00, 1'b0, STS0);
    hit(3'h4, 32'h2000, 5'h00, 1'b0, STS0);
    hit(3'h5, 32'h2000, 5'h00, 1'b1, STS0 | 32'h2);
    hit(3'h4, 32'h3103, 5'h00, 1'b1, STS0 | 32'h4);
    hit(3'h4, 32'h3104, 5'h00, 1'b0, STS0);
    hit(3'h4, 32'h4003, 5'h18, 1'b1, STS0 | 32'h4008);
    hit(3'h5, 32'h4003, 5'h00, 1'b0, STS0);
    hit(3'h0, 32'h0, 5'h01, 1'b1, STS0);
    $display("test breakpoints done");
    // Task switch into a trapped task drops locals only
    hit(3'h0, 32'h0, 5'h06, 1'b1, STS0 | 32'h8000);
    rd(dbu_pkg::SEL_CONTROL, 32'h7f100428, "locals cleared");
    hit(3'h6, 32'h1000, 5'h00, 1'b0, STS0);
    $display("test task switch done");
    // Guarded access traps and drops the guard
    mv(1'b1, dbu_pkg::SEL_CONTROL, dbu_pkg::PRIV_KERNEL, dbu_pkg::CTL_FIXED_ONES | 32'h2000);
    mv(1'b0, dbu_pkg::SEL_ADDR0, dbu_pkg::PRIV_KERNEL, 32'h0);
    chk({30'h0, lastEx, lastRep.done}, 32'h2, "guarded move");
    rd(dbu_pkg::SEL_CONTROL, dbu_pkg::CTL_RESET, "guard cleared");
    $display("test guard done");
    wrap_up();
  end
endmodule

/* File: include/dbu_pkg.sv */
// Package for the debug breakpoint unit: register selects, field layout,
// reset values, access types and the carrier structs.
// Assumes a single core clock and a synchronous active-high reset.
package dbu_pkg;

  // Register select codes carried by the move instruction
  localparam logic [2:0] SEL_ADDR0   = 3'h0;
  localparam logic [2:0] SEL_ADDR1   = 3'h1;
  localparam logic [2:0] SEL_ADDR2   = 3'h2;
  localparam logic [2:0] SEL_ADDR3   = 3'h3;
  localparam logic [2:0] SEL_STATUS  = 3'h6;
  localparam logic [2:0] SEL_CONTROL = 3'h7;

  // Status field positions
  localparam int STS_STEP_BIT = 14;
  localparam int STS_TASK_BIT = 15;

  // Control field positions
  localparam int CTL_GUARD_BIT  = 13;
  localparam int CTL_TYPE_BASE  = 16;
  localparam int CTL_FIELD_STEP = 4;

  // Reserved bits: which are writable, and fixed values elsewhere
  localparam logic [31:0] STS_FIXED_ONES = 32'hffff0ff0;
  localparam logic [31:0] STS_RESET      = 32'hffff0ff0;
  localparam logic [31:0] CTL_WRITE_MASK = 32'hffff23ff;
  localparam logic [31:0] CTL_FIXED_ONES = 32'h00000400;
  localparam logic [31:0] CTL_RESET      = 32'h00000400;
  localparam logic [31:0] ADDR_RESET     = 32'h00000000;

  // Privilege level allowed to move debug registers
  localparam logic [1:0] PRIV_KERNEL = 2'h0;

  // Access-type field codes
  localparam logic [1:0] TYPE_EXEC  = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_RDWR  = 2'h3;

  // Watch-length field codes
  localparam logic [1:0] LEN_ONE  = 2'h0;
  localparam logic [1:0] LEN_TWO  = 2'h1;
  localparam logic [1:0] LEN_FOUR = 2'h3;

  // One memory access from the pipeline, ahead of instruction completion
  typedef struct packed {
    logic        valid;
    logic        isFetch;
    logic        isWrite;
    logic [31:0] linAddr;
  } dbu_access_t;

  // Move-instruction request to a debug register
  typedef struct packed {
    logic        valid;
    logic        isWrite;
    logic [2:0]  sel;
    logic [1:0]  priv;
    logic [31:0] wdata;
  } dbu_move_t;

  // Retire-side events
  typedef struct packed {
    logic retire;
    logic trapFlag;
    logic taskSwitch;
    logic taskTrapBit;
    logic breakInsn;
  } dbu_event_t;

  // Move answer
  typedef struct packed {
    logic        done;
    logic        fault;
    logic [31:0] rdata;
  } dbu_reply_t;

endpackage

/* File: rtl/dbu_debug_breakpoint_unit.sv */
// Debug breakpoint unit: four address breakpoints, control and status
// registers, single-step, task-switch and breakpoint-instruction traps.
// Assumes the pipeline presents accesses before the instruction completes
// and honours the registered exception pulse by holding that instruction.
`timescale 1ns/1ps

module dbu_debug_breakpoint_unit (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire dbu_pkg::dbu_access_t access,
  input  wire dbu_pkg::dbu_move_t   move,
  input  wire dbu_pkg::dbu_event_t  evt,
  output      dbu_pkg::dbu_reply_t  reply,
  output      logic                 debugExc,
  output      logic                 privFault
);

  // Address compare with length mask and type filter
  function automatic logic bp_match(input logic [31:0] bpAddr, input logic [1:0] kind,
                                    input logic [1:0] len, input dbu_pkg::dbu_access_t acc);
    logic [31:0] mask;
    logic        typeOk;
    mask = 32'hffffffff;
    unique case (len)
      dbu_pkg::LEN_TWO:  mask = 32'hfffffffe;
      dbu_pkg::LEN_FOUR: mask = 32'hfffffffc;
      default:           mask = 32'hffffffff;
    endcase
    unique case (kind)
      dbu_pkg::TYPE_EXEC:  typeOk = acc.isFetch;
      dbu_pkg::TYPE_WRITE: typeOk = !acc.isFetch && acc.isWrite;
      dbu_pkg::TYPE_RDWR:  typeOk = !acc.isFetch;
      default:             typeOk = 1'b0; // Unused code never matches
    endcase
    return acc.valid && typeOk && ((acc.linAddr & mask) == (bpAddr & mask));
  endfunction

  logic [31:0] addrQ [4];
  logic [31:0] addrD [4];
  logic [31:0] statusQ, statusD;
  logic [31:0] controlQ, controlD;
  dbu_pkg::dbu_reply_t replyQ, replyD;
  logic        excQ, excD;
  logic        faultQ, faultD;
  logic [3:0]  hitVec;
  logic [3:0]  armed;
  logic        moveOk;
  logic        guardTrap;

  // Per-breakpoint compare and arming from the enable pairs
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hitVec[i] = bp_match(addrQ[i],
                           controlQ[dbu_pkg::CTL_TYPE_BASE + i*dbu_pkg::CTL_FIELD_STEP +: 2],
                           controlQ[dbu_pkg::CTL_TYPE_BASE + i*dbu_pkg::CTL_FIELD_STEP + 2 +: 2],
                           access);
      armed[i]  = controlQ[2*i] || controlQ[2*i+1];
    end
  end

  // Move legality: privilege first, then the guard bit
  assign moveOk    = move.valid && (move.priv == dbu_pkg::PRIV_KERNEL) && !controlQ[dbu_pkg::CTL_GUARD_BIT];
  assign guardTrap = move.valid && (move.priv == dbu_pkg::PRIV_KERNEL) && controlQ[dbu_pkg::CTL_GUARD_BIT];

  // Next state for registers, status and exception
  always_comb begin
    logic trig;
    logic addrTrig;
    logic stepTrig;
    logic taskTrig;
    trig     = 1'b0;
    addrTrig = |(hitVec & armed);
    stepTrig = evt.retire && evt.trapFlag;
    taskTrig = evt.taskSwitch && evt.taskTrapBit;
    for (int i = 0; i < 4; i++) begin
      addrD[i] = addrQ[i];
    end
    statusD  = statusQ; // Set bits hold until software writes it
    controlD = controlQ;
    replyD   = '0;
    faultD   = move.valid && (move.priv != dbu_pkg::PRIV_KERNEL);

    // Software moves; hardware sets below override clears
    if (moveOk) begin
      replyD.done = 1'b1;
      if (move.isWrite) begin
        unique case (move.sel)
          dbu_pkg::SEL_ADDR0:   addrD[0] = move.wdata;
          dbu_pkg::SEL_ADDR1:   addrD[1] = move.wdata;
          dbu_pkg::SEL_ADDR2:   addrD[2] = move.wdata;
          dbu_pkg::SEL_ADDR3:   addrD[3] = move.wdata;
          dbu_pkg::SEL_STATUS:  statusD  = move.wdata | dbu_pkg::STS_FIXED_ONES;
          dbu_pkg::SEL_CONTROL: controlD = (move.wdata & dbu_pkg::CTL_WRITE_MASK) | dbu_pkg::CTL_FIXED_ONES;
          default:              replyD.fault = 1'b1; // Unmapped select
        endcase
      end else begin
        unique case (move.sel)
          dbu_pkg::SEL_ADDR0:   replyD.rdata = addrQ[0];
          dbu_pkg::SEL_ADDR1:   replyD.rdata = addrQ[1];
          dbu_pkg::SEL_ADDR2:   replyD.rdata = addrQ[2];
          dbu_pkg::SEL_ADDR3:   replyD.rdata = addrQ[3];
          dbu_pkg::SEL_STATUS:  replyD.rdata = statusQ;
          dbu_pkg::SEL_CONTROL: replyD.rdata = controlQ;
          default:              replyD.fault = 1'b1;
        endcase
      end
    end

    // Local enables drop on a task switch, global ones stay
    if (evt.taskSwitch) begin
      for (int i = 0; i < 4; i++) begin
        controlD[2*i] = 1'b0;
      end
    end

    trig = addrTrig || stepTrig || taskTrig || evt.breakInsn || guardTrap;
    if (trig) begin
      // Every matching breakpoint is flagged, armed or not
      statusD[3:0] = statusD[3:0] | hitVec;
      if (stepTrig) statusD[dbu_pkg::STS_STEP_BIT] = 1'b1;
      if (taskTrig) statusD[dbu_pkg::STS_TASK_BIT] = 1'b1;
      controlD[dbu_pkg::CTL_GUARD_BIT] = 1'b0;
    end
    excD = trig; // Raised while the access is still pending
  end

  // Register everything; outputs come from these flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        addrQ[i] <= dbu_pkg::ADDR_RESET;
      end
      statusQ  <= dbu_pkg::STS_RESET;
      controlQ <= dbu_pkg::CTL_RESET;
      replyQ   <= '0;
      excQ     <= 1'b0;
      faultQ   <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        addrQ[i] <= addrD[i];
      end
      statusQ  <= statusD;
      controlQ <= controlD;
      replyQ   <= replyD;
      excQ     <= excD;
      faultQ   <= faultD;
    end
  end

  assign reply     = replyQ;
  assign debugExc  = excQ;
  assign privFault = faultQ;

  // Checks: status flags, enables, guard, refusals and traps follow their causes
  step_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    (evt.retire && evt.trapFlag) |=> (debugExc && statusQ[dbu_pkg::STS_STEP_BIT]))
    else $error("single step did not flag");
  task_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    (evt.taskSwitch && evt.taskTrapBit) |=> (debugExc && statusQ[dbu_pkg::STS_TASK_BIT]))
    else $error("task trap did not flag");
  hit_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    (excD && hitVec[0]) |=> statusQ[0])
    else $error("hit flag missing");
  guard_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    excD |=> !controlQ[dbu_pkg::CTL_GUARD_BIT])
    else $error("guard not cleared");
  local_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
    evt.taskSwitch |=> (controlQ[6] == 1'b0 && controlQ[0] == 1'b0))
    else $error("local enable survived switch");
  global_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    (evt.taskSwitch && !moveOk) |=> controlQ[1] == $past(controlQ[1]))
    else $error("global enable changed");
  status_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!moveOk && statusQ[2]) |=> statusQ[2])
    else $error("status cleared by hardware");
  priv_move_a: assert property (@(posedge ref_clk) disable iff (rst)
    (move.valid && move.priv != dbu_pkg::PRIV_KERNEL) |=> (privFault && !reply.done))
    else $error("unprivileged move accepted");
  guard_trap_a: assert property (@(posedge ref_clk) disable iff (rst)
    guardTrap |=> (debugExc && !reply.done))
    else $error("guarded move completed");
  brk_insn_a: assert property (@(posedge ref_clk) disable iff (rst)
    evt.breakInsn |=> debugExc)
    else $error("breakpoint instruction ignored");
  // Any armed compare must trap, whichever slot it is in
  armed_hit_a: assert property (@(posedge ref_clk) disable iff (rst)
    (|(hitVec & armed)) |=> debugExc)
    else $error("armed hit missed");

  // No exception without one of the listed causes
  no_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!(|(hitVec & armed)) && !(evt.retire && evt.trapFlag) && !(evt.taskSwitch && evt.taskTrapBit)
     && !evt.breakInsn && !guardTrap) |=> !debugExc)
    else $error("spurious debug exception");

  // Type filter: fetch, write-only and the unused code
  exec_no_data_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!access.isFetch && controlQ[dbu_pkg::CTL_TYPE_BASE +: 2] == dbu_pkg::TYPE_EXEC) |-> !hitVec[0])
    else $error("data access hit exec slot");
  // A read must never hit a write-only slot
  write_only_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!access.isWrite && controlQ[dbu_pkg::CTL_TYPE_BASE + dbu_pkg::CTL_FIELD_STEP +: 2] == dbu_pkg::TYPE_WRITE)
    |-> !hitVec[1])
    else $error("read hit write-only slot");
  // Unused type code is inert rather than a guess
  unused_type_a: assert property (@(posedge ref_clk) disable iff (rst)
    (controlQ[dbu_pkg::CTL_TYPE_BASE + 2*dbu_pkg::CTL_FIELD_STEP +: 2] == 2'h2) |-> !hitVec[2])
    else $error("unused type matched");

  // Length masks: exact byte, aligned four-byte span
  byte_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    (hitVec[0] && controlQ[dbu_pkg::CTL_TYPE_BASE + 2 +: 2] == dbu_pkg::LEN_ONE) |-> access.linAddr == addrQ[0])
    else $error("byte watch too wide");
  // Only the two low bits may differ on a four-byte watch
  four_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    (hitVec[2] && controlQ[dbu_pkg::CTL_TYPE_BASE + 2*dbu_pkg::CTL_FIELD_STEP + 2 +: 2] == dbu_pkg::LEN_FOUR)
    |-> access.linAddr[31:2] == addrQ[2][31:2])
    else $error("four byte watch misaligned");

  // Enables: either bit of a pair arms its slot
  global_arm_a: assert property (@(posedge ref_clk) disable iff (rst)
    (hitVec[1] && controlQ[3]) |=> debugExc)
    else $error("global enable ignored");
  // Local enable arms while the task lasts
  local_arm_a: assert property (@(posedge ref_clk) disable iff (rst)
    (hitVec[0] && controlQ[0]) |=> debugExc)
    else $error("local enable ignored");

  // Flags only rise on their own causes
  task_no_trap_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!(evt.taskSwitch && evt.taskTrapBit) && !statusQ[dbu_pkg::STS_TASK_BIT] && !moveOk)
    |=> !statusQ[dbu_pkg::STS_TASK_BIT])
    else $error("task flag set without trap");
  // Step flag needs a retire with the trap flag up
  step_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!(evt.retire && evt.trapFlag) && !statusQ[dbu_pkg::STS_STEP_BIT] && !moveOk)
    |=> !statusQ[dbu_pkg::STS_STEP_BIT])
    else $error("step flag set without step");
  // Hit flags are captured only when an exception is taken
  hit_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!excD && !moveOk && !statusQ[1]) |=> !statusQ[1])
    else $error("hit flag set without exception");

  // Status reserved bits hold their fixed values whatever software writes, except bits 12 and 13
  sts_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
    (statusQ & dbu_pkg::STS_FIXED_ONES) == dbu_pkg::STS_FIXED_ONES)
    else $error("status fixed bits lost");
  // Control reserved bits: bit 10 high, the rest low
  ctl_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
    (controlQ & ~(dbu_pkg::CTL_WRITE_MASK | dbu_pkg::CTL_FIXED_ONES)) == 32'h00000000 && controlQ[10])
    else $error("control fixed bits lost");

  // Guard set by software survives until an exception
  guard_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    (moveOk && move.isWrite && move.sel == dbu_pkg::SEL_CONTROL && move.wdata[dbu_pkg::CTL_GUARD_BIT] && !excD)
    |=> controlQ[dbu_pkg::CTL_GUARD_BIT])
    else $error("guard write lost");
  // Refused moves leave the registers alone
  priv_no_effect_a: assert property (@(posedge ref_clk) disable iff (rst)
    (move.valid && move.priv != dbu_pkg::PRIV_KERNEL && !evt.taskSwitch && !excD) |=> controlQ == $past(controlQ))
    else $error("unprivileged move changed control");
  // Address registers untouched by a refused move
  priv_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (move.valid && move.priv != dbu_pkg::PRIV_KERNEL) |=> addrQ[0] == $past(addrQ[0]))
    else $error("unprivileged move changed address");
  // A guarded move must not land either
  guard_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    guardTrap |=> addrQ[0] == $past(addrQ[0]))
    else $error("guarded move changed address");

  // Move answers: one done per legal move, none otherwise
  move_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
    moveOk |=> reply.done)
    else $error("legal move not answered");
  // Quiet port gives quiet answers
  reply_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    !move.valid |=> (!reply.done && !privFault))
    else $error("answer without move");
  // Read data is zero unless a read is answered
  write_rdata_a: assert property (@(posedge ref_clk) disable iff (rst)
    (move.valid && move.isWrite) |=> reply.rdata == 32'h00000000)
    else $error("read data on a write");
  // Address write lands whole
  addr_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (moveOk && move.isWrite && move.sel == dbu_pkg::SEL_ADDR3) |=> addrQ[3] == $past(move.wdata))
    else $error("address write lost");
  // Status read returns the sticky flags as they stood
  status_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (moveOk && !move.isWrite && move.sel == dbu_pkg::SEL_STATUS) |=> reply.rdata == $past(statusQ))
    else $error("status read wrong");

endmodule
